/* hw/vlm_pkg.sv */
// Constants shared by the output-voltage limit and margin register block
package vlm_pkg;
    localparam logic [7:0]  CODE_UPPER_LIMIT = 8'h24;
    localparam logic [7:0]  CODE_MARGIN_HIGH = 8'h25;
    localparam logic [7:0]  CODE_MARGIN_LOW  = 8'h26;
    localparam int          DATA_W           = 16;
    localparam logic [15:0] RST_UPPER_LIMIT  = 16'h0000;
    localparam logic [15:0] RST_MARGIN_HIGH  = 16'h0000;
    localparam logic [15:0] RST_MARGIN_LOW   = 16'h0000;
    localparam logic [15:0] RST_TARGET       = 16'h0000;
    localparam logic [1:0]  MARGIN_NONE      = 2'h0;
    localparam logic [1:0]  MARGIN_LOW_SEL   = 2'h1;
    localparam logic [1:0]  MARGIN_HIGH_SEL  = 2'h2;
    localparam int          CLK_PERIOD_NS    = 50;
    localparam int          SLEW_TICK_NS     = 1000;
    localparam int          SLEW_TICK_CYC    = (SLEW_TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    typedef enum logic [1:0] {
        VLM_HOLD = 2'b00,
        VLM_UP   = 2'b01,
        VLM_DOWN = 2'b11
    } vlm_slew_e;
endpackage : vlm_pkg

/* hw/vlm_slew_if.sv */
// Interface between the register logic and the target slew ramp
`timescale 1ns/10ps
interface vlm_slew_if;
    logic [15:0] goal;
    logic [15:0] step;
    logic [15:0] now;
    logic        settled;
    modport regs (output goal, output step, input now, input settled);
    modport ramp (input goal, input step, output now, output settled);
endinterface : vlm_slew_if

/* hw/vlm_slew.sv */
// Slew ramp that walks the output target toward its goal once per tick
`timescale 1ns/10ps
module vlm_slew
    import vlm_pkg::*;
#(
    parameter int TICK_CYC = SLEW_TICK_CYC
) (
    input  wire logic  clk,
    input  wire logic  rst_n,
    vlm_slew_if.ramp   sl
);
    localparam int CW = $clog2(TICK_CYC + 1);
    localparam logic [CW-1:0] TICK_LAST = CW'(TICK_CYC - 1);

    logic [CW-1:0] tick_cnt;
    logic [15:0]   now;
    vlm_slew_e     state;
    vlm_slew_e     next_state;
    logic [15:0]   next_now;

    wire           tick     = (tick_cnt == TICK_LAST);
    wire  [15:0]   gap_up   = sl.goal - now;
    wire  [15:0]   gap_down = now - sl.goal;
    wire           step_zero = (sl.step == 16'h0000);

    assign sl.now     = now;
    assign sl.settled = (now == sl.goal);

    always_comb begin
        next_state = state;
        next_now   = now;
        case (state)
            VLM_HOLD: begin
                if (sl.goal > now) begin
                    next_state = VLM_UP;
                end else if (sl.goal < now) begin
                    next_state = VLM_DOWN;
                end
            end
            VLM_UP: begin
                if (sl.goal <= now) begin
                    next_state = VLM_HOLD;
                end else if (tick) begin
                    // Zero step jumps straight to the goal
                    next_now = (step_zero || sl.step >= gap_up) ? sl.goal : now + sl.step;
                end
            end
            VLM_DOWN: begin
                if (sl.goal >= now) begin
                    next_state = VLM_HOLD;
                end else if (tick) begin
                    next_now = (step_zero || sl.step >= gap_down) ? sl.goal : now - sl.step;
                end
            end
            default: begin
                next_state = VLM_HOLD;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tick_cnt <= '0;
            now      <= RST_TARGET;
            state    <= VLM_HOLD;
        end else begin
            tick_cnt <= tick ? '0 : tick_cnt + CW'(1);
            now      <= next_now;
            state    <= next_state;
        end
    end
endmodule : vlm_slew

/* hw/vlm_regs.sv */
// Output-voltage upper limit, margin targets, clamping and warning status
//
// How it works
// - Upper limit sits at command 24h; host writes and reads it by word.
// - The upper limit caps every commanded output target regardless of source.
// - Upper limit is 16-bit read/write, loaded from non-volatile memory at power up.
// - With conversion on, a target above the limit raises the limit warning.
// - A violating target is moved to the limit through the slew ramp.
// - Violation sets none-of-above, status-word output bit and the limit warning bit.
// - Violation notifies the host through the alert line.
// - Writing a limit below the present target clamps, flags and notifies likewise.
// - Margin-high target at 25h is 16-bit read/write, loaded from memory.
// - Margin high selected gives target margin-high plus trim.
// - Margin-low target at 26h is 16-bit read/write, loaded from memory.
// - Margin low selected gives target margin-low plus trim.
// - Entering or leaving margin slews at the configured rate.
// - Margin plus trim is bounded by the limit like the nominal command.
// - Out-of-range margin writes are rejected, flagged invalid and the host notified.
// - Trim is a signed offset added to the selected value, applied via slew.
`timescale 1ns/10ps
module vlm_regs
    import vlm_pkg::*;
#(
    parameter int TICK_CYC = SLEW_TICK_CYC
) (
    input  wire logic        CLK,
    input  wire logic        RST_N,
    input  wire logic        NVM_LOAD,
    input  wire logic [15:0] NVM_UPPER_LIMIT,
    input  wire logic [15:0] NVM_MARGIN_HIGH,
    input  wire logic [15:0] NVM_MARGIN_LOW,
    input  wire logic        CMD_WR,
    input  wire logic        CMD_RD,
    input  wire logic [7:0]  CMD_CODE,
    input  wire logic [15:0] CMD_WDATA,
    output logic      [15:0] CMD_RDATA,
    output logic             CMD_RVALID,
    output logic             CMD_UNSUP,
    input  wire logic [15:0] VOUT_NOMINAL,
    input  wire logic [15:0] VOUT_TRIM,
    input  wire logic [1:0]  OP_MARGIN,
    input  wire logic        CONV_EN,
    input  wire logic [15:0] DAC_MAX,
    input  wire logic [15:0] SLEW_STEP,
    input  wire logic        CLEAR_FAULTS,
    output logic      [15:0] TARGET,
    output logic             TARGET_SETTLED,
    output logic             STS_NONE_OF_ABOVE,
    output logic             STS_WORD_VOUT,
    output logic             LIMIT_WARNING_BIT,
    output logic             STS_INVALID_DATA,
    output logic             ALERT_N
);
    ////////////////////////////////////////////////////////////////////////
    // Registers and decode
    logic [15:0] output_voltage_upper_limit;
    logic [15:0] margin_high_target;
    logic [15:0] margin_low_target;
    logic        warn;
    logic        invalid;
    logic        alert;

    wire hit_limit = (CMD_CODE == CODE_UPPER_LIMIT);
    wire hit_high  = (CMD_CODE == CODE_MARGIN_HIGH);
    wire hit_low   = (CMD_CODE == CODE_MARGIN_LOW);
    wire hit_any   = hit_limit | hit_high | hit_low;
    wire wr_limit  = CMD_WR & hit_limit;

    ////////////////////////////////////////////////////////////////////////
    // Target selection and bounds
    wire margin_high_field = (OP_MARGIN == MARGIN_HIGH_SEL);
    wire margin_low_field  = (OP_MARGIN == MARGIN_LOW_SEL);

    wire [15:0] sel_base = margin_high_field ? margin_high_target :
                           margin_low_field  ? margin_low_target  :
                           VOUT_NOMINAL;

    // Signed 18-bit sum so a negative trim cannot wrap to a huge target
    wire signed [17:0] sum = $signed({2'b00, sel_base}) + $signed({{2{VOUT_TRIM[15]}}, VOUT_TRIM});
    wire        sum_neg  = sum[17];
    wire [16:0] sum_mag  = sum_neg ? 17'h00000 : sum[16:0];
    wire        over_lim = (sum_mag > {1'b0, output_voltage_upper_limit});

    // Limit clamp reports; hardware range clamp is silent
    wire [15:0] lim_goal = over_lim ? output_voltage_upper_limit : sum_mag[15:0];
    wire [15:0] goal     = (lim_goal > DAC_MAX) ? DAC_MAX : lim_goal;
    wire        limit_violation_condition = CONV_EN & over_lim;

    // A margin write is out of range if it plus trim leaves the hardware range
    wire signed [17:0] wsum = $signed({2'b00, CMD_WDATA}) + $signed({{2{VOUT_TRIM[15]}}, VOUT_TRIM});
    wire        wr_bad   = wsum[17] | (wsum[16:0] > {1'b0, DAC_MAX});
    wire        wr_margin = CMD_WR & (hit_high | hit_low);
    wire        reject   = wr_margin & wr_bad;
    wire        wr_high  = CMD_WR & hit_high & ~wr_bad;
    wire        wr_low   = CMD_WR & hit_low & ~wr_bad;

    wire [15:0] rd_mux = hit_limit ? output_voltage_upper_limit :
                         hit_high  ? margin_high_target :
                         hit_low   ? margin_low_target  : 16'h0000;

    // Setting flags beat a clear in the same cycle
    wire next_warn    = (warn & ~CLEAR_FAULTS) | limit_violation_condition;
    wire next_invalid = (invalid & ~CLEAR_FAULTS) | reject;

    ////////////////////////////////////////////////////////////////////////
    // Slew ramp
    vlm_slew_if sl_if ();
    assign sl_if.goal = goal;
    assign sl_if.step = SLEW_STEP;

    vlm_slew #(
        .TICK_CYC (TICK_CYC)
    ) u_slew (
        .clk   (CLK),
        .rst_n (RST_N),
        .sl    (sl_if)
    );

    ////////////////////////////////////////////////////////////////////////
    // Storage
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            output_voltage_upper_limit <= RST_UPPER_LIMIT;
        end else if (NVM_LOAD) begin
            output_voltage_upper_limit <= NVM_UPPER_LIMIT;
        end else if (wr_limit) begin
            output_voltage_upper_limit <= CMD_WDATA;
        end
    end

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            margin_high_target <= RST_MARGIN_HIGH;
            margin_low_target  <= RST_MARGIN_LOW;
        end else if (NVM_LOAD) begin
            margin_high_target <= NVM_MARGIN_HIGH;
            margin_low_target  <= NVM_MARGIN_LOW;
        end else begin
            if (wr_high) begin
                margin_high_target <= CMD_WDATA;
            end
            if (wr_low) begin
                margin_low_target <= CMD_WDATA;
            end
        end
    end

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            warn    <= 1'b0;
            invalid <= 1'b0;
            alert   <= 1'b0;
        end else begin
            warn    <= next_warn;
            invalid <= next_invalid;
            alert   <= next_warn | next_invalid;
        end
    end

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            CMD_RDATA  <= 16'h0000;
            CMD_RVALID <= 1'b0;
            CMD_UNSUP  <= 1'b0;
        end else begin
            CMD_RVALID <= CMD_RD & hit_any;
            CMD_UNSUP  <= (CMD_RD | CMD_WR) & ~hit_any;
            if (CMD_RD) begin
                CMD_RDATA <= rd_mux;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs
    assign TARGET            = sl_if.now;
    assign TARGET_SETTLED    = sl_if.settled;
    assign STS_NONE_OF_ABOVE = warn | invalid;
    assign STS_WORD_VOUT     = warn;
    assign LIMIT_WARNING_BIT = warn;
    assign STS_INVALID_DATA  = invalid;
    assign ALERT_N           = ~alert;
endmodule : vlm_regs

/* tb/vlm_regs_monitor.sv */
// Checker for the limit and margin register block
`timescale 1ns/10ps
module vlm_regs_monitor
    import vlm_pkg::*;
(
    input wire logic       CLK,
    input wire logic       RST_N,
    input wire logic       CMD_WR,
    input wire logic       CMD_RD,
    input wire logic [7:0] CMD_CODE,
    input wire logic       CMD_RVALID,
    input wire logic       CMD_UNSUP,
    input wire logic       CONV_EN,
    input wire logic       CLEAR_FAULTS,
    input wire logic       STS_NONE_OF_ABOVE,
    input wire logic       STS_WORD_VOUT,
    input wire logic       LIMIT_WARNING_BIT,
    input wire logic       STS_INVALID_DATA,
    input wire logic       ALERT_N,
    input wire logic [15:0] TARGET,
    input wire logic [15:0] SLEW_STEP
);
    default clocking @(posedge CLK); endclocking
    default disable iff (!RST_N);
    wire logic mapped = CMD_CODE inside {CODE_UPPER_LIMIT, CODE_MARGIN_HIGH, CODE_MARGIN_LOW};
    wire logic rd_ok  = CMD_RD && mapped;
    wire logic any_fl = LIMIT_WARNING_BIT || STS_INVALID_DATA;
    sequence s_read_req; CMD_RD && mapped; endsequence
    sequence s_read_ans; CMD_RVALID && !CMD_UNSUP; endsequence
    a_read_answer: assert property (s_read_req |=> s_read_ans) else $error("read not answered");
    a_rvalid_cause: assert property (CMD_RVALID |-> $past(rd_ok)) else $error("stray read valid");
    a_unmapped_flag: assert property ((CMD_RD || CMD_WR) && !mapped |=> CMD_UNSUP && !CMD_RVALID)
        else $error("unmapped code not refused");
    a_warn_reports: assert property ($rose(LIMIT_WARNING_BIT) |-> STS_WORD_VOUT && STS_NONE_OF_ABOVE && !ALERT_N)
        else $error("warning not reported");
    a_alert_flags: assert property (ALERT_N == !any_fl) else $error("alert level wrong");
    a_none_above: assert property (STS_NONE_OF_ABOVE == any_fl) else $error("summary bit wrong");
    a_warn_sticky: assert property (LIMIT_WARNING_BIT && !CLEAR_FAULTS |=> LIMIT_WARNING_BIT)
        else $error("warning dropped");
    a_invalid_sticky: assert property (STS_INVALID_DATA && !CLEAR_FAULTS |=> STS_INVALID_DATA)
        else $error("invalid flag dropped");
    a_warn_needs_conv: assert property (!CONV_EN && !LIMIT_WARNING_BIT |=> !LIMIT_WARNING_BIT)
        else $error("warning while off");
    a_target_step: assert property ($changed(TARGET) |-> SLEW_STEP == 16'h0000 ||
        ((TARGET > $past(TARGET)) ? (TARGET - $past(TARGET)) : ($past(TARGET) - TARGET)) <= SLEW_STEP)
        else $error("target moved more than one step");
endmodule : vlm_regs_monitor
bind vlm_regs vlm_regs_monitor u_mon (.CLK, .RST_N, .CMD_WR, .CMD_RD, .CMD_CODE, .CMD_RVALID, .CMD_UNSUP,
    .CONV_EN, .CLEAR_FAULTS, .STS_NONE_OF_ABOVE, .STS_WORD_VOUT, .LIMIT_WARNING_BIT, .STS_INVALID_DATA, .ALERT_N,
    .TARGET, .SLEW_STEP);

/* tb/vlm_host.sv */
// Host model issuing word reads and writes on the command port
`timescale 1ns/10ps
module vlm_host (
    input  wire logic        CLK,
    output logic             CMD_WR,
    output logic             CMD_RD,
    output logic      [7:0]  CMD_CODE,
    output logic      [15:0] CMD_WDATA,
    input  wire logic [15:0] CMD_RDATA,
    input  wire logic        CMD_RVALID,
    input  wire logic        CMD_UNSUP
);
    initial begin
        CMD_WR = 1'b0;
        CMD_RD = 1'b0;
        CMD_CODE = 8'h00;
        CMD_WDATA = 16'h0000;
    end
    task automatic wr(input logic [7:0] code, input logic [15:0] data);
        @(posedge CLK);
        CMD_WR <= 1'b1;
        CMD_CODE <= code;
        CMD_WDATA <= data;
        @(posedge CLK);
        CMD_WR <= 1'b0;
        // Released data no longer shows the written word
        CMD_WDATA <= ~data;
    endtask : wr
    task automatic rd(input logic [7:0] code, output logic [15:0] data, output logic [1:0] fl);
        @(posedge CLK);
        CMD_RD <= 1'b1;
        CMD_CODE <= code;
        @(posedge CLK);
        CMD_RD <= 1'b0;
        #1;
        data = CMD_RDATA;
        fl = {CMD_RVALID, CMD_UNSUP};
    endtask : rd
endmodule : vlm_host

/* tb/vlm_regs_tb.sv */
// Self-checking bench for the limit and margin register block
`timescale 1ns/10ps
module vlm_regs_tb;
    import vlm_pkg::*;
    logic        CLK = 1'b0, RST_N = 1'b0, nvm_ld = 1'b0, conv = 1'b0, clr = 1'b0;
    logic [1:0]  marg = 2'h0;
    logic [15:0] nom = 16'h0100, trim = 16'h0000, dac = 16'h0800, step = 16'h0040, nvm_v = 16'h0300;
    wire logic        wr, rd, rvalid, unsup, settled, noa, word, warn, inval, alert_n;
    wire logic [7:0]  code;
    wire logic [15:0] wdata, rdata, target;
    wire logic [4:0]  flg = {alert_n, warn, word, noa, inval};
    int          failures = 0, check_count = 0;
    logic [7:0]  codes [3] = '{CODE_UPPER_LIMIT, CODE_MARGIN_HIGH, CODE_MARGIN_LOW};
    logic [15:0] wv [3] = '{16'h0400, 16'h0250, 16'h0080};
    logic [49:0] tv [6] = '{{2'h0, 16'h0010, 16'h0110, 16'h0}, {2'h1, 16'h0010, 16'h0090, 16'h0},
        {2'h2, 16'h0010, 16'h0260, 16'h0}, {2'h3, 16'h0010, 16'h0110, 16'h0},
        {2'h1, 16'hFF00, 16'h0000, 16'h0}, {2'h2, 16'hFFF0, 16'h0240, 16'h0}};
    vlm_host u_host (.CLK(CLK), .CMD_WR(wr), .CMD_RD(rd), .CMD_CODE(code), .CMD_WDATA(wdata),
        .CMD_RDATA(rdata), .CMD_RVALID(rvalid), .CMD_UNSUP(unsup));
    vlm_regs #(.TICK_CYC(2)) dut (.CLK(CLK), .RST_N(RST_N), .NVM_LOAD(nvm_ld), .NVM_UPPER_LIMIT(nvm_v),
        .NVM_MARGIN_HIGH(nvm_v - 16'h0100), .NVM_MARGIN_LOW(nvm_v - 16'h0200), .CMD_WR(wr), .CMD_RD(rd),
        .CMD_CODE(code), .CMD_WDATA(wdata), .CMD_RDATA(rdata), .CMD_RVALID(rvalid), .CMD_UNSUP(unsup),
        .VOUT_NOMINAL(nom), .VOUT_TRIM(trim), .OP_MARGIN(marg), .CONV_EN(conv), .DAC_MAX(dac),
        .SLEW_STEP(step), .CLEAR_FAULTS(clr), .TARGET(target), .TARGET_SETTLED(settled),
        .STS_NONE_OF_ABOVE(noa), .STS_WORD_VOUT(word), .LIMIT_WARNING_BIT(warn),
        .STS_INVALID_DATA(inval), .ALERT_N(alert_n));
    initial forever #25 CLK = ~CLK;
    task automatic test_done();
        if (failures == 0 && check_count > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : test_done
    task automatic chk(input logic [19:0] got, input logic [19:0] exp);
        check_count++;
        if (got !== exp) begin
            failures++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic rdchk(input logic [7:0] c, input logic [1:0] ef, input logic [15:0] e);
        logic [15:0] d;
        logic [1:0]  f;
        u_host.rd(c, d, f);
        chk({2'b00, f, d}, {2'b00, ef, e});
    endtask : rdchk
    // Waits for the ramp to land, then compares target and status flags
    task automatic settle(input logic [15:0] e, input logic [4:0] ef);
        repeat (400) begin
            @(negedge CLK);
            if (settled === 1'b1 && target === e) break;
        end
        chk({target, 3'h0, settled}, {e, 4'h1});
        chk(20'(flg), 20'(ef));
    endtask : settle
    task automatic op(input logic [1:0] m, input logic [15:0] t);
        @(posedge CLK);
        marg <= m;
        trim <= t;
    endtask : op
    task automatic pulse_clr();
        @(posedge CLK);
        clr <= 1'b1;
        @(posedge CLK);
        clr <= 1'b0;
    endtask : pulse_clr
    initial begin
        repeat (4) @(posedge CLK);
        RST_N <= 1'b1;
        foreach (codes[i]) rdchk(codes[i], 2'b10, 16'h0000);
        // Zero limit clamps the target, but with conversion off no warning is raised
        settle(16'h0000, 5'b10000);
        @(posedge CLK);
        nvm_ld <= 1'b1;
        @(posedge CLK);
        nvm_ld <= 1'b0;
        conv   <= 1'b1;
        foreach (codes[i]) rdchk(codes[i], 2'b10, nvm_v - 16'(i) * 16'h0100);
        foreach (codes[i]) u_host.wr(codes[i], wv[i]);
        foreach (codes[i]) rdchk(codes[i], 2'b10, wv[i]);
        rdchk(8'h23, 2'b01, 16'h0000);
        foreach (tv[i]) begin
            op(tv[i][49:48], tv[i][47:32]);
            settle(tv[i][31:16], 5'b10000);
        end
        op(2'h2, 16'h01C0);
        settle(16'h0400, 5'b01110);
        op(2'h0, 16'h0010);
        settle(16'h0110, 5'b01110);
        pulse_clr();
        settle(16'h0110, 5'b10000);
        u_host.wr(CODE_UPPER_LIMIT, 16'h0100);
        settle(16'h0100, 5'b01110);
        u_host.wr(CODE_UPPER_LIMIT, 16'h0400);
        pulse_clr();
        u_host.wr(CODE_MARGIN_LOW, 16'h0900);
        rdchk(CODE_MARGIN_LOW, 2'b10, 16'h0080);
        settle(16'h0110, 5'b00011);
        pulse_clr();
        @(posedge CLK);
        conv <= 1'b0;
        op(2'h2, 16'h01C0);
        settle(16'h0400, 5'b10000);
        test_done();
    end
    initial begin
        repeat (20000) @(posedge CLK);
        failures++;
        test_done();
    end
endmodule : vlm_regs_tb
